// [hw/tca_access.sv]
// tca_access: cpu byte access to three 16-bit timers and their compare banks.
// assumes one byte access per cycle on the internal register bus and ticks from a prescaler.
// Contract
// [RL1] counter readable and writable as high and low byte locations
// [RL2] 16-bit accesses pass through an 8-bit high-byte holding latch, atomically
// [RL3] one latch shared by all 16-bit registers; software must not interleave
// [RL4] counter write suppresses compare matches on the next timer tick
// [RL5] software should avoid writing a running counter, matches may be missed
// [RL6] three compare values per timer, high and low byte, reset zero
// [RL7] each compare value checked against counter every tick; equality is a match
// [RL8] high write waits in latch for low write; low read loads latch with high
`timescale 1ns/100ps
`default_nettype none
module tca_access (
   // clock and reset
   input  wire logic                                      clk,
   input  wire logic                                      rstn,
   // cpu register bus
   input  wire tca_pkg::tca_bus_req_t                     req,
   output logic [7:0]                                     rdata,
   // timer ticks
   input  wire logic [tca_pkg::NUM_TIMERS-1:0]            tick,
   // results towards waveform and interrupt logic
   output logic [tca_pkg::NUM_TIMERS-1:0][tca_pkg::NUM_CH-1:0] match,
   output logic [tca_pkg::NUM_TIMERS-1:0][15:0]           count
);

   tca_pkg::tca_top_st_t  st_q;
   tca_pkg::tca_top_st_t  st_d;
   tca_pkg::tca_unit_wr_t uw [tca_pkg::NUM_TIMERS];
   tca_pkg::tca_unit_st_t us [tca_pkg::NUM_TIMERS];

   // the latch is shared on purpose: one byte of storage for every 16-bit register,
   // paid for by software keeping its byte pairs unbroken
   always_comb begin
      st_d = st_q;
      for (int t = 0; t < tca_pkg::NUM_TIMERS; t++) begin
         uw[t].cnt_wr = 1'b0;
         uw[t].cmp_wr = '0;
         uw[t].data   = {st_q.temp, req.wdata}; // [RL2] [RL3]
      end
      if (req.rd) begin
         st_d.rdata = tca_pkg::RDATA_UNMAPPED;
      end
      for (int t = 0; t < tca_pkg::NUM_TIMERS; t++) begin
         if (req.addr == tca_pkg::CNT_LOW_OFS[t]) begin
            if (req.wr) begin
               uw[t].cnt_wr = 1'b1; // [RL1] [RL8]
            end
            if (req.rd) begin
               st_d.rdata = us[t].count[7:0]; // [RL1]
               st_d.temp  = us[t].count[15:8]; // [RL8]
            end
         end else if (req.addr == tca_pkg::CNT_HIGH_OFS[t]) begin
            if (req.wr) begin
               st_d.temp = req.wdata; // [RL8]
            end
            if (req.rd) begin
               st_d.rdata = st_q.temp; // [RL2]
            end
         end
         for (int ch = 0; ch < tca_pkg::NUM_CH; ch++) begin
            if (req.addr == tca_pkg::CMP_LOW_OFS[t][ch]) begin
               if (req.wr) begin
                  uw[t].cmp_wr[ch] = 1'b1; // [RL6] [RL8]
               end
               if (req.rd) begin
                  st_d.rdata = us[t].cmp[ch][7:0]; // [RL6]
                  st_d.temp  = us[t].cmp[ch][15:8]; // [RL8]
               end
            end else if (req.addr == tca_pkg::CMP_HIGH_OFS[t][ch]) begin
               if (req.wr) begin
                  st_d.temp = req.wdata; // [RL8]
               end
               if (req.rd) begin
                  st_d.rdata = st_q.temp; // [RL2]
               end
            end
         end
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         st_q.temp  <= tca_pkg::TEMP_RESET;
         st_q.rdata <= tca_pkg::RDATA_RESET;
      end else begin
         st_q <= st_d;
      end
   end

   for (genvar t = 0; t < tca_pkg::NUM_TIMERS; t++) begin : g_timer
      tca_unit i_tca_unit (
         .clk  (clk),
         .rstn (rstn),
         .tick (tick[t]),
         .wr   (uw[t]),
         .st   (us[t])
      );
   end

   // one driver per result port; the unit outputs are already registered
   always_comb begin
      for (int t = 0; t < tca_pkg::NUM_TIMERS; t++) begin
         match[t] = us[t].match;
         count[t] = us[t].count;
      end
   end

   assign rdata = st_q.rdata;

   sequence s_t1a_high_wr;
      req.wr && req.addr == tca_pkg::CMP_HIGH_OFS[0][0];
   endsequence

   sequence s_t1a_low_wr;
      req.wr && req.addr == tca_pkg::CMP_LOW_OFS[0][0];
   endsequence

   sequence s_t3b_low_wr;
      req.wr && req.addr == tca_pkg::CMP_LOW_OFS[1][1];
   endsequence

   sequence s_t1_cnt_high_wr;
      req.wr && req.addr == tca_pkg::CNT_HIGH_OFS[0];
   endsequence

   sequence s_t1_cnt_low_wr;
      req.wr && req.addr == tca_pkg::CNT_LOW_OFS[0];
   endsequence

   // pair checks cover a cpu that leaves one quiet cycle between the two bytes
   sequence s_idle;
      !req.wr && !req.rd;
   endsequence

   AST_ATOMIC_CMP: assert property (@(posedge clk) disable iff (!rstn) // [RL2]
      s_t1a_high_wr ##1 s_idle ##1 s_t1a_low_wr |=>
         us[0].cmp[0] == {$past(req.wdata, 3), $past(req.wdata)})
      else $error("compare value not written as one 16-bit word");

   AST_SHARED_LATCH: assert property (@(posedge clk) disable iff (!rstn) // [RL3]
      s_t1a_high_wr ##1 s_idle ##1 s_t3b_low_wr |=>
         us[1].cmp[1] == {$past(req.wdata, 3), $past(req.wdata)})
      else $error("latch not shared between 16-bit registers");

   AST_HIGH_HELD: assert property (@(posedge clk) disable iff (!rstn) // [RL8]
      s_t1a_high_wr ##1 !req.wr |=> us[0].cmp[0] == $past(us[0].cmp[0], 2))
      else $error("high byte write changed compare value early");

   AST_LOW_RD_CAPTURE: assert property (@(posedge clk) disable iff (!rstn) // [RL8]
      req.rd && !req.wr && req.addr == tca_pkg::CNT_LOW_OFS[0] |=>
         st_q.temp == $past(us[0].count[15:8]) && rdata == $past(us[0].count[7:0]))
      else $error("low byte read did not capture high byte");

   AST_HIGH_RD: assert property (@(posedge clk) disable iff (!rstn) // [RL2]
      req.rd && !req.wr && req.addr == tca_pkg::CNT_HIGH_OFS[2] |=> rdata == $past(st_q.temp))
      else $error("high byte read not served from latch");

   AST_UNMAPPED: assert property (@(posedge clk) disable iff (!rstn)
      req.rd && req.addr == 8'h00 |=> rdata == tca_pkg::RDATA_UNMAPPED)
      else $error("unmapped read returned nonzero");

   AST_CNT_ATOMIC: assert property (@(posedge clk) disable iff (!rstn) // [RL1]
      s_t1_cnt_high_wr ##1 s_idle ##1 s_t1_cnt_low_wr |=>
         us[0].count == {$past(req.wdata, 3), $past(req.wdata)})
      else $error("counter not written as one 16-bit word");

   AST_CMP_LOW_RD: assert property (@(posedge clk) disable iff (!rstn) // [RL6] [RL8]
      req.rd && req.addr == tca_pkg::CMP_LOW_OFS[2][1] |=>
         rdata == $past(us[2].cmp[1][7:0]) && st_q.temp == $past(us[2].cmp[1][15:8]))
      else $error("compare low byte read wrong or high byte not latched");

   AST_HIGH_WR_LATCH: assert property (@(posedge clk) disable iff (!rstn) // [RL8]
      req.wr && req.addr == tca_pkg::CMP_HIGH_OFS[1][0] |=> st_q.temp == $past(req.wdata))
      else $error("high byte write did not reach the latch");

   AST_CNT_WR_BLOCKS: assert property (@(posedge clk) disable iff (!rstn) // [RL4]
      req.wr && req.addr == tca_pkg::CNT_LOW_OFS[2] |=> us[2].block)
      else $error("counter write did not block the next match");

   AST_MATCH_OUT: assert property (@(posedge clk) disable iff (!rstn) // [RL7]
      tick[1] && !us[1].block && us[1].count == us[1].cmp[2] |=> match[1][2])
      else $error("equal compare value gave no match on the result port");

   AST_NO_TICK_NO_MATCH: assert property (@(posedge clk) disable iff (!rstn) // [RL7]
      !tick[0] |=> match[0] == '0)
      else $error("match raised without a timer tick");

   // read data is registered and must stand until the next read
   AST_RDATA_HOLD: assert property (@(posedge clk) disable iff (!rstn)
      !req.rd |=> rdata == $past(rdata))
      else $error("read data changed without a read");

endmodule : tca_access
`default_nettype wire

// [hw/tca_pkg.sv]
// tca_pkg: constants and carrier types for the timer count/compare access block.
// assumes an 8-bit cpu register bus with byte addresses and a timer tick from a prescaler.
package tca_pkg;

   localparam int NUM_TIMERS = 3;
   localparam int NUM_CH     = 3;

   // timer order: timer 1, timer 3, timer 4; channel order: a, b, c
   localparam logic [7:0] CNT_LOW_OFS  [NUM_TIMERS] = '{8'h84, 8'h94, 8'ha4};
   localparam logic [7:0] CNT_HIGH_OFS [NUM_TIMERS] = '{8'h85, 8'h95, 8'ha5};
   // timer 4 channel b has its high byte below its low byte
   localparam logic [7:0] CMP_LOW_OFS  [NUM_TIMERS][NUM_CH] = '{'{8'h88, 8'h8a, 8'h8c},
                                                                '{8'h98, 8'h9a, 8'h9c},
                                                                '{8'ha8, 8'hab, 8'hac}};
   localparam logic [7:0] CMP_HIGH_OFS [NUM_TIMERS][NUM_CH] = '{'{8'h89, 8'h8b, 8'h8d},
                                                                '{8'h99, 8'h9b, 8'h9d},
                                                                '{8'ha9, 8'haa, 8'had}};

   localparam logic [15:0] CNT_RESET      = 16'h0000;
   localparam logic [15:0] CMP_RESET      = 16'h0000;
   localparam logic [15:0] CNT_STEP       = 16'h0001;
   localparam logic [7:0]  TEMP_RESET     = 8'h00;
   localparam logic [7:0]  RDATA_RESET    = 8'h00;
   localparam logic [7:0]  RDATA_UNMAPPED = 8'h00;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } tca_bus_req_t;

   typedef struct packed {
      logic              cnt_wr;
      logic [NUM_CH-1:0] cmp_wr;
      logic [15:0]       data;
   } tca_unit_wr_t;

   typedef struct packed {
      logic [15:0]                   count;
      logic [NUM_CH-1:0][15:0]       cmp;
      logic                          block;
      logic [NUM_CH-1:0]             match;
   } tca_unit_st_t;

   typedef struct packed {
      logic [7:0] temp;
      logic [7:0] rdata;
   } tca_top_st_t;

endpackage : tca_pkg

// [hw/tca_unit.sv]
// tca_unit: one timer's 16-bit counter, its compare values and the match detection.
// assumes 16-bit writes arrive already assembled by the access logic around it.
`timescale 1ns/100ps
`default_nettype none
module tca_unit (
   // clock and reset
   input  wire logic                  clk,
   input  wire logic                  rstn,
   // timer clock tick, one cycle wide
   input  wire logic                  tick,
   // assembled 16-bit writes
   input  wire tca_pkg::tca_unit_wr_t wr,
   // registered state, match pulses included
   output var tca_pkg::tca_unit_st_t  st
);

   tca_pkg::tca_unit_st_t st_q;
   tca_pkg::tca_unit_st_t st_d;

   always_comb begin
      st_d       = st_q;
      st_d.match = '0;
      if (tick) begin
         for (int ch = 0; ch < tca_pkg::NUM_CH; ch++) begin
            st_d.match[ch] = !st_q.block && (st_q.count == st_q.cmp[ch]); // [RL7] [RL4]
         end
         st_d.count = st_q.count + tca_pkg::CNT_STEP;
         st_d.block = 1'b0;
      end
      // a cpu write beats the tick; the next tick is then blind to matches
      if (wr.cnt_wr) begin
         st_d.count = wr.data; // [RL1]
         st_d.block = 1'b1; // [RL4]
      end
      for (int ch = 0; ch < tca_pkg::NUM_CH; ch++) begin
         if (wr.cmp_wr[ch]) begin
            st_d.cmp[ch] = wr.data; // [RL6]
         end
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         st_q.count <= tca_pkg::CNT_RESET;
         st_q.cmp   <= {tca_pkg::NUM_CH{tca_pkg::CMP_RESET}};
         st_q.block <= 1'b0;
         st_q.match <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign st = st_q;

   sequence s_cnt_write;
      wr.cnt_wr;
   endsequence

   sequence s_blind_tick;
      st_q.block && tick;
   endsequence

   AST_BLOCK_ARMED: assert property (@(posedge clk) disable iff (!rstn) // [RL4]
      s_cnt_write |=> st_q.block)
      else $error("counter write did not arm match blocking");

   AST_BLIND_TICK: assert property (@(posedge clk) disable iff (!rstn) // [RL4]
      s_blind_tick |=> st_q.match == '0)
      else $error("match seen on tick after counter write");

   AST_MATCH_EQ: assert property (@(posedge clk) disable iff (!rstn) // [RL7]
      tick && !st_q.block && (st_q.count == st_q.cmp[0]) |=> st_q.match[0])
      else $error("equal compare value gave no match");

   AST_CNT_STEP: assert property (@(posedge clk) disable iff (!rstn) // [RL1]
      tick && !wr.cnt_wr |=> st_q.count == $past(st_q.count) + tca_pkg::CNT_STEP)
      else $error("counter did not advance on tick");

   AST_CNT_LOAD: assert property (@(posedge clk) disable iff (!rstn) // [RL1]
      wr.cnt_wr |=> st_q.count == $past(wr.data) && st_q.block)
      else $error("counter write value not taken");

endmodule : tca_unit
`default_nettype wire

// [testbench/tca_cpu_model.sv]
// tca_cpu_model: the cpu on the 8-bit register bus, one byte access per acc call, two per wr16 or rd16 call.
// assumes rdata is registered and valid after the edge that takes a read.
`timescale 1ns/100ps
`default_nettype none
module tca_cpu_model (
   // clock
   input  wire logic                 clk,
   // register bus
   output var tca_pkg::tca_bus_req_t req,
   input  wire logic [7:0]           rdata
);
   initial req = '{addr: 8'h00, wdata: 8'h00, wr: 1'b0, rd: 1'b0};

   task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d,
                      output logic [7:0] q);
      @(posedge clk);
      #1;
      req = '{addr: a, wdata: d, wr: w, rd: ~w};
      @(posedge clk);
      #1;
      q = rdata;
      // released lines show the inverse so a stale value never passes
      req = '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
   endtask : acc

   // high byte first, pairs never interleaved
   task automatic wr16(input logic [7:0] lo, input logic [7:0] hi, input logic [15:0] d);
      logic [7:0] q;
      acc(1'b1, hi, d[15:8], q);
      acc(1'b1, lo, d[7:0], q);
   endtask : wr16

   // low byte first so the latch captures the high byte
   task automatic rd16(input logic [7:0] lo, input logic [7:0] hi, output logic [15:0] v);
      acc(1'b0, lo, 8'h00, v[7:0]);
      acc(1'b0, hi, 8'h00, v[15:8]);
   endtask : rd16
endmodule : tca_cpu_model
`default_nettype wire

// [testbench/test_tca_access.sv]
// test_tca_access: register access, shared latch and match blocking of tca_access.
// assumes the cpu model drives the bus and this bench drives the ticks.
`timescale 1ns/100ps
`default_nettype none
module test_tca_access;
   logic                                              clk;
   logic                                              rstn;
   logic [2:0]                                        tick;
   tca_pkg::tca_bus_req_t                             req;
   logic [7:0]                                        rdata;
   logic [tca_pkg::NUM_TIMERS-1:0][tca_pkg::NUM_CH-1:0] match;
   logic [tca_pkg::NUM_TIMERS-1:0][15:0]              count;
   int                                                num_errors;
   int                                                n_tests;
   logic [15:0]                                       v;
   logic [7:0]                                        b;

   tca_access i_tca_access (.clk(clk), .rstn(rstn), .req(req), .rdata(rdata),
                            .tick(tick), .match(match), .count(count));
   tca_cpu_model i_tca_cpu_model (.clk(clk), .req(req), .rdata(rdata));

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic final_report;
      $display("checks %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : final_report

   task automatic pulse(input int t);
      @(posedge clk);
      #1;
      tick[t] = 1'b1;
      @(posedge clk);
      #1;
      tick = 3'h0;
   endtask : pulse

   function automatic logic [15:0] pat(input int t, input int c);
      return 16'(16'h1357 * (t * 3 + c + 1));
   endfunction : pat

   initial begin
      #100000;
      num_errors++;
      final_report();
   end

   initial begin
      num_errors = 0;
      n_tests = 0;
      rstn = 1'b0;
      tick = 3'h0;
      repeat (20) @(posedge clk);
      #1;
      rstn = 1'b1;
      for (int t = 0; t < 3; t++) begin
         i_tca_cpu_model.rd16(tca_pkg::CNT_LOW_OFS[t], tca_pkg::CNT_HIGH_OFS[t], v);
         check("count reset", v, tca_pkg::CNT_RESET);
         for (int c = 0; c < 3; c++) begin
            i_tca_cpu_model.rd16(tca_pkg::CMP_LOW_OFS[t][c], tca_pkg::CMP_HIGH_OFS[t][c], v);
            check("compare reset", v, tca_pkg::CMP_RESET);
            i_tca_cpu_model.wr16(tca_pkg::CMP_LOW_OFS[t][c], tca_pkg::CMP_HIGH_OFS[t][c],
                                 pat(t, c));
         end
      end
      for (int t = 0; t < 3; t++)
         for (int c = 0; c < 3; c++) begin
            i_tca_cpu_model.rd16(tca_pkg::CMP_LOW_OFS[t][c], tca_pkg::CMP_HIGH_OFS[t][c], v);
            check("compare readback", v, pat(t, c));
         end
      // high byte of one register completes the low write of another
      i_tca_cpu_model.acc(1'b1, tca_pkg::CMP_HIGH_OFS[0][0], 8'h77, b);
      i_tca_cpu_model.acc(1'b1, tca_pkg::CMP_LOW_OFS[1][1], 8'h11, b);
      i_tca_cpu_model.rd16(tca_pkg::CMP_LOW_OFS[1][1], tca_pkg::CMP_HIGH_OFS[1][1], v);
      check("shared latch", v, 16'h7711);
      i_tca_cpu_model.acc(1'b0, 8'h00, 8'h00, b);
      check("unmapped read", {8'h00, b}, {8'h00, tca_pkg::RDATA_UNMAPPED});
      // counter is written only while no tick runs; the match on a at the first tick after it is blocked
      for (int t = 0; t < 3; t++) begin
         for (int c = 0; c < 3; c++)
            i_tca_cpu_model.wr16(tca_pkg::CMP_LOW_OFS[t][c], tca_pkg::CMP_HIGH_OFS[t][c],
                                 16'(5 + c));
         i_tca_cpu_model.wr16(tca_pkg::CNT_LOW_OFS[t], tca_pkg::CNT_HIGH_OFS[t], 16'h0005);
         check("count written", count[t], 16'h0005);
         pulse(t);
         check("blocked match", {13'h0, match[t]}, 16'h0000);
         pulse(t);
         check("match b", {13'h0, match[t]}, 16'h0002);
         pulse(t);
         check("match c", {13'h0, match[t]}, 16'h0004);
         check("count ticks", count[t], 16'h0008);
      end
      // only the first tick after a counter write is blind; the second one matches
      i_tca_cpu_model.wr16(tca_pkg::CNT_LOW_OFS[0], tca_pkg::CNT_HIGH_OFS[0], 16'h0004);
      pulse(0);
      check("blind tick", {13'h0, match[0]}, 16'h0000);
      pulse(0);
      check("match a", {13'h0, match[0]}, 16'h0001);
      // low read freezes the high byte while the counter carries
      i_tca_cpu_model.wr16(tca_pkg::CNT_LOW_OFS[0], tca_pkg::CNT_HIGH_OFS[0], 16'h01ff);
      i_tca_cpu_model.acc(1'b0, tca_pkg::CNT_LOW_OFS[0], 8'h00, b);
      check("count low", {8'h00, b}, 16'h00ff);
      pulse(0);
      i_tca_cpu_model.acc(1'b0, tca_pkg::CNT_HIGH_OFS[0], 8'h00, b);
      check("count high latched", {8'h00, b}, 16'h0001);
      check("count carried", count[0], 16'h0200);
      final_report();
   end
endmodule : test_tca_access
`default_nettype wire
